// *** design/dog_defs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef DOG_DEFS_SVH
`define DOG_DEFS_SVH

// ----------------------------------------------------------------
// clock rates and base time-outs
// ----------------------------------------------------------------
`define PCLK_HZ          50000000
`define LOW_POWER_RC_CLOCK_HZ          32000
`define LOW_POWER_RC_CLOCK_DIV_CYCLES  (`PCLK_HZ / `LOW_POWER_RC_CLOCK_HZ)
`define BASE_MS_SHORT    1
`define BASE_MS_LONG     4
`define PRE_DIV_SHORT    (`LOW_POWER_RC_CLOCK_HZ * `BASE_MS_SHORT / 1000)
`define PRE_DIV_LONG     (`LOW_POWER_RC_CLOCK_HZ * `BASE_MS_LONG / 1000)

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CONFIG       12'h000
`define OFF_RESET_CTRL   12'h004
`define OFF_IRQ_STATUS   12'h008
`define OFF_IRQ_MASK     12'h00c
`define OFF_DOG_STATE    12'h010

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RC_IDLE_BIT      2
`define RC_SLEEP_BIT     3
`define RC_TIMEOUT_BIT   4
`define RC_SW_EN_BIT     5
`define IRQ_TIMEOUT_BIT  0
`define IRQ_EARLY_BIT    1
`define IRQ_WAKE_BIT     2
`define ST_WINDOW_BIT    24
`define ST_RUNNING_BIT   25

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CFG_RESET        8'h5f
`define IRQ_MASK_RESET   3'h0

`endif

// *** design/dog_pkg.sv ***
// types shared by the watchdog design files
package dog_pkg;

	// power mode of the core, one-hot
	typedef enum logic [2:0] {
		MODE_RUN   = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_IDLE  = 3'b100
	} mode_e;

	// watchdog configuration word, bit 7 down to bit 0
	typedef struct packed {
		logic       hw_dog_enable;
		logic       window_disable;
		logic       spare;
		logic       prescale_select;
		logic [3:0] postscale_select;
	} cfg_s;

	// sticky event flags of the reset control register
	typedef struct packed {
		logic timeout_flag;
		logic sleep_flag;
		logic idle_flag;
	} rc_flags_s;

endpackage

// *** design/step_counter.sv ***
// wrapping counter with a variable last value and a terminal pulse
`timescale 1ns/1ns
`default_nettype none

module step_counter #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         clear,
	input  wire logic         step,
	input  wire logic [W-1:0] last,
	// state
	output logic      [W-1:0] count,
	output logic              wrap
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (clear) begin
			count_next = '0;
		end else if (step) begin
			if (count_reg >= last) begin
				count_next = '0;
			end else begin
				count_next = count_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count = count_reg;
	assign wrap  = step & (count_reg >= last);

endmodule

`default_nettype wire

// *** design/sticky_flags.sv ***
// sticky flags: hardware set wins over a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none

module sticky_flags #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// events and clears
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// state
	output logic      [W-1:0] flags
);

	logic [W-1:0] flags_reg;
	logic [W-1:0] flags_next;

	always_comb begin
		flags_next = (flags_reg & ~clr) | set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags = flags_reg;

endmodule

`default_nettype wire

// *** design/windowed_watchdog_timer.sv ***
// windowed watchdog timer with apb registers and power-save wake
//
// What this block does
// - runs from rc clock, enabled with watchdog
// - prescaler divides by 32 or 128
// - base time-out 1 ms or 4 ms
// - postscaler 1:1 to 1:32768, sixteen settings
// - finished clock switch clears counter chain
// - power-save entry clears counter chain
// - leaving power-save clears counter chain
// - clear instruction clears counter chain
// - keeps counting in sleep and idle
// - time-out wakes core; software clears mode flags
// - time-out flag sticky until software clears
// - hardware enable forces watchdog on
// - otherwise software enable bit runs it
// - device reset clears software enable
// - early clear in window mode resets
`timescale 1ns/1ns
`default_nettype none
`include "dog_defs.svh"

module windowed_watchdog_timer
	import dog_pkg::*;
#(
	parameter int LOW_POWER_RC_CLOCK_DIV = `LOW_POWER_RC_CLOCK_DIV_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core and clock events, one-cycle pulses
	input  wire logic        clear_dog_instr,
	input  wire logic        power_save_instr,
	input  wire logic        power_save_idle,
	input  wire logic        other_wake,
	input  wire logic        clk_switch_done,
	input  wire logic        sys_reset,
	// outputs to core, oscillator and reset logic
	output logic             low_power_rc_clock_en,
	output logic             dog_reset_req,
	output logic             wake_req,
	output logic             in_power_save,
	output logic             irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam int PRE_W  = 7;
	localparam int POST_W = 15;
	localparam int LDIV_W = 12;

	cfg_s              cfg_reg, cfg_next;
	logic              sw_en_reg, sw_en_next;
	logic [2:0]        mask_reg, mask_next;
	mode_e             mode_reg, mode_next;
	logic              low_power_rc_clock_on_reg, low_power_rc_clock_on_next;
	logic              reset_req_reg, reset_req_next;
	logic              wake_reg, wake_next;
	logic              irq_reg, irq_next;
	logic [31:0]       prdata_reg, prdata_next;
	logic              pready_reg, pready_next;
	logic              pslverr_reg, pslverr_next;
	logic              dog_enabled, running, clr_instr;
	logic              enter_save, leave_save, early_clear;
	logic              timeout, chain_clear, base_clear;
	logic [LDIV_W-1:0] ldiv_last;
	logic              low_power_rc_clock_tick, pre_wrap, post_wrap;
	logic [PRE_W-1:0]  pre_last, pre_count;
	logic [POST_W-1:0] post_last, post_count;
	logic [2:0]        pre_shift;
	logic [21:0]       elapsed;
	logic [24:0]       elapsed_x4, period_x3;
	logic              in_window;
	logic              access, addr_ok;
	logic              wr_config, wr_rc, wr_status, wr_mask;
	rc_flags_s         rc_set, rc_clr, rc_flags;
	logic [2:0]        irq_set, irq_clr, irq_status;

	// ----------------------------------------------------------------
	// enable, mode and chain-clear conditions
	// ----------------------------------------------------------------
	assign dog_enabled = cfg_reg.hw_dog_enable | sw_en_reg;
	assign running     = (mode_reg == MODE_RUN);
	assign clr_instr   = clear_dog_instr & running & dog_enabled;
	assign enter_save  = power_save_instr & running;
	assign leave_save  = ~running & (other_wake | (post_wrap & dog_enabled));

	// an early clear only counts while window mode is on
	assign early_clear = clr_instr & ~cfg_reg.window_disable & ~in_window;

	assign base_clear = ~dog_enabled
		| sys_reset
		| clk_switch_done
		| enter_save
		| clr_instr;

	// an explicit clear in the same cycle beats the time-out
	assign timeout = post_wrap & dog_enabled & ~base_clear;

	assign chain_clear = base_clear
		| leave_save
		| timeout;

	// ----------------------------------------------------------------
	// counter chain
	// ----------------------------------------------------------------
	assign ldiv_last = LDIV_W'(LOW_POWER_RC_CLOCK_DIV - 1);

	// rc clock stands in as a tick divided down from pclk
	step_counter #(
		.W(LDIV_W)
	) u_low_power_rc_clock (
		.pclk   (pclk),
		.presetn(presetn),
		.clear  (~low_power_rc_clock_on_reg),
		.step   (1'b1),
		.last   (ldiv_last),
		.count  (),
		.wrap   (low_power_rc_clock_tick)
	);

	assign pre_last  = cfg_reg.prescale_select ? PRE_W'(`PRE_DIV_LONG - 1)
		: PRE_W'(`PRE_DIV_SHORT - 1);
	assign pre_shift = cfg_reg.prescale_select ? 3'd7 : 3'd5;

	step_counter #(
		.W(PRE_W)
	) u_pre (
		.pclk   (pclk),
		.presetn(presetn),
		.clear  (chain_clear),
		.step   (low_power_rc_clock_tick),
		.last   (pre_last),
		.count  (pre_count),
		.wrap   (pre_wrap)
	);

	// 1:1 .. 1:32768 as a power of two of the setting
	assign post_last = POST_W'((32'd1 << cfg_reg.postscale_select) - 32'd1);

	step_counter #(
		.W(POST_W)
	) u_post (
		.pclk   (pclk),
		.presetn(presetn),
		.clear  (chain_clear),
		.step   (pre_wrap),
		.last   (post_last),
		.count  (post_count),
		.wrap   (post_wrap)
	);

	// ----------------------------------------------------------------
	// clear window: last quarter of the full period
	// ----------------------------------------------------------------
	always_comb begin
		elapsed    = 22'({7'h00, post_count} << pre_shift) | 22'(pre_count);
		elapsed_x4 = {1'b0, elapsed, 2'b00};
		period_x3  = 25'(25'h0000003 << (5'(cfg_reg.postscale_select)
			+ 5'(pre_shift)));
		in_window  = (elapsed_x4 >= period_x3);
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign access    = psel & penable & pready_reg;
	assign wr_config = access & pwrite & (paddr == `OFF_CONFIG);
	assign wr_rc     = access & pwrite & (paddr == `OFF_RESET_CTRL);
	assign wr_status = access & pwrite & (paddr == `OFF_IRQ_STATUS);
	assign wr_mask   = access & pwrite & (paddr == `OFF_IRQ_MASK);

	always_comb begin
		case (paddr)
			`OFF_CONFIG:     addr_ok = 1'b1;
			`OFF_RESET_CTRL: addr_ok = 1'b1;
			`OFF_IRQ_STATUS: addr_ok = 1'b1;
			`OFF_IRQ_MASK:   addr_ok = 1'b1;
			`OFF_DOG_STATE:  addr_ok = ~pwrite;
			default:         addr_ok = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// sticky flags
	// ----------------------------------------------------------------
	always_comb begin
		rc_set.timeout_flag = timeout | early_clear;
		rc_set.sleep_flag   = enter_save & ~power_save_idle;
		rc_set.idle_flag    = enter_save & power_save_idle;
		// software clears a flag by writing zero to it
		rc_clr.timeout_flag = wr_rc & ~pwdata[`RC_TIMEOUT_BIT];
		rc_clr.sleep_flag   = wr_rc & ~pwdata[`RC_SLEEP_BIT];
		rc_clr.idle_flag    = wr_rc & ~pwdata[`RC_IDLE_BIT];
		irq_set = 3'h0;
		irq_set[`IRQ_TIMEOUT_BIT] = timeout & running;
		irq_set[`IRQ_EARLY_BIT]   = early_clear;
		irq_set[`IRQ_WAKE_BIT]    = timeout & ~running;
		irq_clr = wr_status ? pwdata[2:0] : 3'h0;
	end

	sticky_flags #(
		.W(3)
	) u_rc_flags (
		.pclk   (pclk),
		.presetn(presetn),
		.set    (rc_set),
		.clr    (rc_clr),
		.flags  (rc_flags)
	);

	sticky_flags #(
		.W(3)
	) u_irq_flags (
		.pclk   (pclk),
		.presetn(presetn),
		.set    (irq_set),
		.clr    (irq_clr),
		.flags  (irq_status)
	);

	// ----------------------------------------------------------------
	// control registers and mode, next values
	// ----------------------------------------------------------------
	always_comb begin
		cfg_next   = cfg_reg;
		sw_en_next = sw_en_reg;
		mask_next  = mask_reg;
		mode_next  = mode_reg;
		if (wr_config) begin
			cfg_next = cfg_s'(pwdata[7:0]);
			cfg_next.spare = 1'b0;
			// once set, hardware enable holds until power-on reset
			cfg_next.hw_dog_enable = cfg_reg.hw_dog_enable | pwdata[7];
		end
		if (wr_rc) begin
			sw_en_next = pwdata[`RC_SW_EN_BIT];
		end
		if (sys_reset) begin
			sw_en_next = 1'b0;
		end
		if (wr_mask) begin
			mask_next = pwdata[2:0];
		end
		case (mode_reg)
			MODE_RUN: begin
				if (enter_save) begin
					mode_next = power_save_idle ? MODE_IDLE : MODE_SLEEP;
				end
			end
			MODE_SLEEP, MODE_IDLE: begin
				if (leave_save) begin
					mode_next = MODE_RUN;
				end
			end
			default: begin
				mode_next = MODE_RUN;
			end
		endcase
		if (sys_reset) begin
			mode_next = MODE_RUN;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg   <= cfg_s'(`CFG_RESET);
			sw_en_reg <= 1'b0;
			mask_reg  <= `IRQ_MASK_RESET;
			mode_reg  <= MODE_RUN;
		end else begin
			cfg_reg   <= cfg_next;
			sw_en_reg <= sw_en_next;
			mask_reg  <= mask_next;
			mode_reg  <= mode_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs and apb answer, next values
	// ----------------------------------------------------------------
	always_comb begin
		low_power_rc_clock_on_next   = dog_enabled;
		reset_req_next = (timeout & running) | early_clear;
		wake_next      = timeout & ~running;
		irq_next       = |(irq_status & mask_reg);
		pready_next    = psel & penable & ~pready_reg;
		pslverr_next   = psel & penable & ~pready_reg & ~addr_ok;
		prdata_next    = 32'h0000_0000;
		if (psel & penable & ~pready_reg & ~pwrite) begin
			case (paddr)
				`OFF_CONFIG: begin
					prdata_next[7:0] = cfg_reg;
				end
				`OFF_RESET_CTRL: begin
					prdata_next[`RC_SW_EN_BIT]   = sw_en_reg;
					prdata_next[`RC_TIMEOUT_BIT] = rc_flags.timeout_flag;
					prdata_next[`RC_SLEEP_BIT]   = rc_flags.sleep_flag;
					prdata_next[`RC_IDLE_BIT]    = rc_flags.idle_flag;
				end
				`OFF_IRQ_STATUS: begin
					prdata_next[2:0] = irq_status;
				end
				`OFF_IRQ_MASK: begin
					prdata_next[2:0] = mask_reg;
				end
				`OFF_DOG_STATE: begin
					prdata_next[21:0] = elapsed;
					prdata_next[`ST_WINDOW_BIT]  = in_window;
					prdata_next[`ST_RUNNING_BIT] = dog_enabled;
				end
				default: begin
					prdata_next = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_power_rc_clock_on_reg   <= 1'b0;
			reset_req_reg <= 1'b0;
			wake_reg      <= 1'b0;
			irq_reg       <= 1'b0;
			prdata_reg    <= 32'h0000_0000;
			pready_reg    <= 1'b0;
			pslverr_reg   <= 1'b0;
		end else begin
			low_power_rc_clock_on_reg   <= low_power_rc_clock_on_next;
			reset_req_reg <= reset_req_next;
			wake_reg      <= wake_next;
			irq_reg       <= irq_next;
			prdata_reg    <= prdata_next;
			pready_reg    <= pready_next;
			pslverr_reg   <= pslverr_next;
		end
	end

	assign low_power_rc_clock_en = low_power_rc_clock_on_reg;
	assign dog_reset_req         = reset_req_reg;
	assign wake_req              = wake_reg;
	assign in_power_save         = ~mode_reg[0];
	assign irq                   = irq_reg;
	assign prdata                = prdata_reg;
	assign pready                = pready_reg;
	assign pslverr               = pslverr_reg;

endmodule

`default_nettype wire

// *** test/dog_checker_properties.sv ***
// concurrent checks on the ports of the watchdog timer
`timescale 1ns/1ns
`default_nettype none
module dog_checker #(
	parameter int LOW_POWER_RC_CLOCK_DIV = 4
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// events and watchdog outputs
	input wire logic        power_save_instr,
	input wire logic        clk_switch_done,
	input wire logic        sys_reset,
	input wire logic        low_power_rc_clock_en,
	input wire logic        dog_reset_req,
	input wire logic        wake_req,
	input wire logic        in_power_save
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access; psel && penable && !pready; endsequence
	sequence s_enter; power_save_instr && !in_power_save; endsequence
	sequence s_quiet8; !dog_reset_req [*8]; endsequence
	property p_wait; s_access |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("access not answered");
	property p_once; pready |=> !pready; endproperty
	a_once: assert property (p_once) else $error("pready held too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without pready");
	property p_idle_data; !pready |-> prdata == 32'h0; endproperty
	a_idle_data: assert property (p_idle_data) else $error("read data idle");
	property p_req_pulse; dog_reset_req |=> !dog_reset_req; endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("long req");
	property p_rc_on; dog_reset_req || wake_req |-> low_power_rc_clock_en;
	endproperty
	a_rc_on: assert property (p_rc_on) else $error("rc clock off");
	property p_enter; s_enter |=> (in_power_save && !wake_req) [*8];
	endproperty
	a_enter: assert property (p_enter) else $error("bad entry");
	property p_wake; wake_req |-> $past(in_power_save) ##1 !in_power_save;
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake");
	property p_ps_noreq; in_power_save |-> !dog_reset_req; endproperty
	a_ps_noreq: assert property (p_ps_noreq) else $error("req asleep");
	property p_switch; clk_switch_done |=> s_quiet8; endproperty
	a_switch: assert property (p_switch) else $error("switch no clear");
	property p_sysrst; sys_reset |=> s_quiet8; endproperty
	a_sysrst: assert property (p_sysrst) else $error("reset no clear");
endmodule
bind windowed_watchdog_timer dog_checker #(.LOW_POWER_RC_CLOCK_DIV(LOW_POWER_RC_CLOCK_DIV)) dog_checker_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.power_save_instr(power_save_instr), .clk_switch_done(clk_switch_done),
	.sys_reset(sys_reset), .low_power_rc_clock_en(low_power_rc_clock_en),
	.dog_reset_req(dog_reset_req), .wake_req(wake_req),
	.in_power_save(in_power_save));
`default_nettype wire

// *** test/reset_model.sv ***
// device reset logic: turns a watchdog request into a reset pulse
`timescale 1ns/1ns
`default_nettype none
module reset_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// request in, reset out
	input  wire logic       dog_reset_req,
	input  wire logic [2:0] dly,
	output logic            sys_reset
);
	int cnt;
	// answers dly+1 cycles after the request is sampled, prompt or slow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= -1;
			sys_reset <= 1'b0;
		end else begin
			sys_reset <= (cnt == 0);
			if (dog_reset_req)
				cnt <= int'(dly);
			else if (cnt >= 0)
				cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int LD = 4;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        idle_sel = 0, pready, pslverr, rc_en, req, wake, in_ps, irq;
	logic        sys_reset;
	logic [1:0]  k;
	logic [2:0]  dly = '0;
	logic [3:0]  ev = '0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r, rng = 32'hb89b572d;
	int          error_cnt = 0, n_compared = 0, cyc = 0, evs = 0, n, t;
	windowed_watchdog_timer #(.LOW_POWER_RC_CLOCK_DIV(LD)) windowed_watchdog_timer_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clear_dog_instr(ev[0]),
		.power_save_instr(ev[1]), .power_save_idle(idle_sel),
		.other_wake(ev[2]), .clk_switch_done(ev[3]), .sys_reset(sys_reset),
		.low_power_rc_clock_en(rc_en), .dog_reset_req(req), .wake_req(wake),
		.in_power_save(in_ps), .irq(irq));
	reset_model reset_model_i (.pclk(pclk), .presetn(presetn),
		.dog_reset_req(req), .dly(dly), .sys_reset(sys_reset));
	initial forever #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	// time-out length in clock cycles
	function automatic int period(input int p, input int s);
		return LD * (p ? 128 : 32) << s;
	endfunction
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	// wait c cycles, counting watchdog events
	task automatic tick(input int c);
		repeat (c) begin
			@(posedge pclk);
			evs += int'(req === 1'b1 || wake === 1'b1);
		end
	endtask
	task automatic pulse(input int b);
		@(posedge pclk);
		ev[b] <= 1'b1;
		@(posedge pclk);
		ev[b] <= 1'b0;
	endtask
	task automatic wait_ev();
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (req !== 1'b1 && wake !== 1'b1);
		k = {wake, req};
	endtask
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] e, input logic err);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; pready ends this wait, or else the bench timeout
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		if (!w)
			chk(prdata, e);
		chk(32'(pslverr), 32'(err));
		{psel, penable} <= 2'b00;
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk(32'(rc_en), 0);
		acc(0, 12'h000, 0, 32'h5f, 0);
		acc(0, 12'h004, 0, 0, 0);
		acc(0, 12'h008, 0, 0, 0);
		acc(0, 12'h00c, 0, 0, 0);
		acc(0, 12'h010, 0, 0, 0);
		acc(0, 12'h020, 0, 0, 1);
		acc(1, 12'h010, 0, 0, 1);
		for (int p = 0; p < 2; p++)
			for (int s = 0; s < 3; s++) begin
				r = xs();
				dly <= r[2:0];
				r[7:0] = 8'h40 | 8'(p << 4) | 8'(s);
				acc(1, 12'h000, r, 0, 0);
				acc(0, 12'h000, 0, 32'(r[7:0]), 0);
				acc(1, 12'h004, 32'h20, 0, 0);
				wait_ev();
				t = period(p, s);
				chk_rng(n, t - LD, t + LD + 4);
				chk(32'(k), 1);
				tick(12);
				acc(0, 12'h004, 0, 32'h10, 0);
				acc(0, 12'h008, 0, 1, 0);
				acc(1, 12'h004, 0, 0, 0);
				acc(0, 12'h004, 0, 0, 0);
				acc(1, 12'h008, 32'h7, 0, 0);
			end
		t = period(0, 1);
		acc(1, 12'h000, 32'h41, 0, 0);
		acc(1, 12'h004, 32'h20, 0, 0);
		evs = 0;
		for (int i = 0; i < 4; i++) begin
			r = xs();
			tick(t * 5 / 8 + int'(r[4:0]));
			pulse(i % 2 == 0 ? 0 : 3);
		end
		tick(t / 2);
		chk(32'(evs), 0);
		acc(1, 12'h000, 32'h01, 0, 0);
		pulse(0);
		wait_ev();
		chk_rng(n, 1, 4);
		chk(32'(k), 1);
		tick(12);
		acc(0, 12'h004, 0, 32'h10, 0);
		acc(0, 12'h008, 0, 2, 0);
		acc(1, 12'h008, 32'h7, 0, 0);
		acc(1, 12'h004, 32'h20, 0, 0);
		evs = 0;
		tick(t * 7 / 8);
		pulse(0);
		tick(t * 3 / 4);
		chk(32'(evs), 0);
		pulse(1);
		tick(2);
		chk(32'(in_ps), 1);
		wait_ev();
		chk_rng(n, t - LD - 2, t + LD + 4);
		chk(32'(k), 2);
		tick(2);
		chk(32'(in_ps), 0);
		acc(0, 12'h004, 0, 32'h38, 0);
		acc(0, 12'h008, 0, 4, 0);
		chk(32'(irq), 0);
		acc(1, 12'h00c, 32'h7, 0, 0);
		tick(2);
		chk(32'(irq), 1);
		acc(1, 12'h008, 32'h4, 0, 0);
		tick(2);
		chk(32'(irq), 0);
		acc(1, 12'h004, 32'h20, 0, 0);
		idle_sel <= 1'b1;
		pulse(1);
		tick(t / 2);
		pulse(2);
		wait_ev();
		chk_rng(n, t - LD, t + LD + 4);
		chk(32'(k), 1);
		tick(12);
		acc(0, 12'h004, 0, 32'h14, 0);
		acc(1, 12'h000, 32'hc0, 0, 0);
		acc(1, 12'h000, 32'h40, 0, 0);
		acc(0, 12'h000, 0, 32'hc0, 0);
		chk(32'(rc_en), 1);
		wait_ev();
		chk(32'(k), 1);
		tick(12);
		chk(32'(rc_en), 1);
		finish_test();
	end
endmodule
`default_nettype wire
